// ==== src/acmp_comparator_control_regs.sv ====
// Design decision made here: strobed register access.
`timescale 1ns/1ns
module acmp_comparator_control_regs
	import acmp_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Register bus.
	input wire acmp_bus_type bus_i,
	output logic [7:0] rdata_o,
	// Sleep state from the power manager.
	input wire logic standby_i,
	input wire logic power_down_i,
	// Analog core.
	input wire logic cmp_raw_i,
	output acmp_analog_type analog_o,
	// Pad and event network.
	output logic pad_o,
	output logic pad_oe_o,
	output logic event_o,
	// Interrupt request.
	output logic irq_o
);

	// Software-visible registers.
	logic [7:0] comparator_control;
	logic [7:0] input_select_control;
	logic [7:0] irq_enable_control;
	logic irq_flag;

	// Synchroniser chain; stage 0 is read only by stage 1.
	logic [ACMP_SYNC_STAGES-1:0] sync;
	// Previous synchronised, inverted sample for edge detection.
	logic prev_sample;
	// Edge detection primed since the status logic last became active.
	logic primed;

	// Field views.
	logic run_in_standby;
	logic pad_output_enable;
	logic [1:0] edge_select;
	logic comparator_enable;
	logic output_invert;
	logic running;
	logic active;
	logic curr_sample;
	logic inv_raw;
	logic edge_event;
	logic flag_clear;

	assign run_in_standby = comparator_control[ACMP_CTRL_RUNSTBY_BIT]; // [R01]
	assign pad_output_enable = comparator_control[ACMP_CTRL_PADEN_BIT];
	assign edge_select = comparator_control[ACMP_CTRL_EDGE_LSB +: 2];
	assign comparator_enable = comparator_control[ACMP_CTRL_ENABLE_BIT];
	assign output_invert = input_select_control[ACMP_MUX_INVERT_BIT];

	// Comparator powered: enabled, not power-down, and not halted standby.
	assign running = comparator_enable & ~power_down_i
		& (~standby_i | run_in_standby); // [R01] [R06] [R17]
	// Status logic only advances while the peripheral clock is live.
	assign active = running & ~standby_i; // [R02] [R18]

	// Inverted raw result feeds pad and event asynchronously.
	assign inv_raw = cmp_raw_i ^ output_invert; // [R07]
	// The last stage is the value software sees.
	assign curr_sample = sync[ACMP_SYNC_STAGES-1];

	// Analog settings pass straight from the registers; enable is the running state.
	always_comb
	begin
		analog_o.enable = running; // [R06]
		analog_o.hysteresis = acmp_hyst_type'(
			comparator_control[ACMP_CTRL_HYST_LSB +: 2]); // [R05]
		analog_o.positive_sel =
			input_select_control[ACMP_MUX_POS_LSB +: 2]; // [R08]
		analog_o.negative_sel = acmp_neg_type'(
			input_select_control[ACMP_MUX_NEG_LSB +: 2]); // [R09]
	end

	// Pad drive: requires enable bit and a running comparator.
	assign pad_oe_o = pad_output_enable & running; // [R03] [R17]
	assign pad_o = pad_oe_o & inv_raw; // [R03] [R07]
	// Event follows the result whenever the comparator runs.
	assign event_o = running & inv_raw; // [R16] [R07]

	// Edge found between the last two synchronised samples.
	assign edge_event = active & primed
		& acmp_edge_hit(edge_select, prev_sample, curr_sample); // [R04] [R14] [R18]

	// Software clears the flag with a one in its bit.
	assign flag_clear = bus_i.wr & (bus_i.addr == ACMP_STATUS_ADDR)
		& bus_i.wdata[ACMP_STAT_FLAG_BIT]; // [R12]

	// Request stays high while flag and enable are both set.
	assign irq_o = irq_flag & irq_enable_control[ACMP_IRQEN_BIT]; // [R10] [R15]

	// Control registers; reserved bits are masked on write.
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			comparator_control <= ACMP_REG_RESET; // [R13]
			input_select_control <= ACMP_REG_RESET; // [R13]
			irq_enable_control <= ACMP_REG_RESET; // [R13]
		end
		else if (bus_i.wr)
		begin
			case (bus_i.addr)
				ACMP_CTRL_ADDR:
					comparator_control <= bus_i.wdata & ACMP_CTRL_MASK;
				ACMP_MUX_ADDR:
					input_select_control <= bus_i.wdata & ACMP_MUX_MASK;
				ACMP_IRQEN_ADDR:
					irq_enable_control <= bus_i.wdata & ACMP_IRQEN_MASK;
				default:
				begin
					// Status and unmapped writes leave control alone.
				end
			endcase
		end
	end

	// Synchroniser; it keeps sampling so the state bit stays fresh.
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			sync <= '0;
		end
		else
		begin
			sync <= {sync[ACMP_SYNC_STAGES-2:0], inv_raw}; // [R11] [R07]
		end
	end

	// Previous sample; priming skips the first sample after start-up.
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			prev_sample <= 1'b0;
			primed <= 1'b0;
		end
		else if (active)
		begin
			prev_sample <= curr_sample; // [R18]
			primed <= 1'b1;
		end
		else
		begin
			// Re-prime after any halt so stale samples make no edge.
			primed <= 1'b0;
		end
	end

	// Interrupt flag; a new edge wins over a clear in the same cycle.
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			irq_flag <= 1'b0; // [R13]
		end
		else if (edge_event)
		begin
			irq_flag <= 1'b1; // [R14]
		end
		else if (flag_clear)
		begin
			irq_flag <= 1'b0; // [R12]
		end
	end

	// Read data register; unmapped offsets read zero.
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			rdata_o <= ACMP_REG_RESET;
		end
		else if (bus_i.rd)
		begin
			case (bus_i.addr)
				ACMP_CTRL_ADDR: rdata_o <= comparator_control;
				ACMP_MUX_ADDR: rdata_o <= input_select_control;
				ACMP_IRQEN_ADDR: rdata_o <= irq_enable_control;
				ACMP_STATUS_ADDR:
				begin
					rdata_o <= ACMP_REG_RESET;
					rdata_o[ACMP_STAT_STATE_BIT] <= curr_sample; // [R11]
					rdata_o[ACMP_STAT_FLAG_BIT] <= irq_flag;
				end
				default: rdata_o <= ACMP_REG_RESET;
			endcase
		end
		else
		begin
			rdata_o <= ACMP_REG_RESET;
		end
	end

endmodule : acmp_comparator_control_regs

// ==== src/acmp_pkg.sv ====
// Summary of operation
// R01 - Run-in-standby bit keeps comparator alive in standby.
// R02 - No flag or interrupt update during standby.
// R03 - Pad output enable drives result to pin.
// R04 - Edge select: both, falling, rising; one reserved.
// R05 - Hysteresis field passed to analog core.
// R06 - Enable bit switches comparator on or off.
// R07 - Invert bit flips result for every consumer.
// R08 - Positive input select passed to analog mux.
// R09 - Negative input select: pins, reference, converter.
// R10 - Interrupt enable bit gates the request.
// R11 - State bit shows synchronised result, three cycles.
// R12 - Flag cleared by writing one only.
// R13 - All registers read zero after reset.
// R14 - Selected edge sets the interrupt flag.
// R15 - Request high while enabled flag is set.
// R16 - Enabled comparator drives result as event.
// R17 - Power-down disables comparator and pad output.
// R18 - Edge detect on synchronised samples, only running.
package acmp_pkg;

	// Register offsets.
	localparam logic [2:0] ACMP_CTRL_ADDR = 3'h0;
	localparam logic [2:0] ACMP_MUX_ADDR = 3'h2;
	localparam logic [2:0] ACMP_IRQEN_ADDR = 3'h6;
	localparam logic [2:0] ACMP_STATUS_ADDR = 3'h7;

	// Control register field positions.
	localparam int ACMP_CTRL_RUNSTBY_BIT = 7;
	localparam int ACMP_CTRL_PADEN_BIT = 6;
	localparam int ACMP_CTRL_EDGE_LSB = 4;
	localparam int ACMP_CTRL_HYST_LSB = 1;
	localparam int ACMP_CTRL_ENABLE_BIT = 0;

	// Input select register field positions.
	localparam int ACMP_MUX_INVERT_BIT = 7;
	localparam int ACMP_MUX_POS_LSB = 3;
	localparam int ACMP_MUX_NEG_LSB = 0;

	// Interrupt enable and status field positions.
	localparam int ACMP_IRQEN_BIT = 0;
	localparam int ACMP_STAT_STATE_BIT = 4;
	localparam int ACMP_STAT_FLAG_BIT = 0;

	// Writable bit masks; other bits are reserved and read zero.
	localparam logic [7:0] ACMP_CTRL_MASK = 8'hF7;
	localparam logic [7:0] ACMP_MUX_MASK = 8'h9B;
	localparam logic [7:0] ACMP_IRQEN_MASK = 8'h01;

	// Reset value of every register.
	localparam logic [7:0] ACMP_REG_RESET = 8'h00;

	// Number of flip-flops between the analog output and the state bit.
	localparam int ACMP_SYNC_STAGES = 3;

	// Edge select encodings.
	typedef enum logic [1:0]
	{
		ACMP_EDGE_ANY = 2'h0,
		ACMP_EDGE_RSVD = 2'h1,
		ACMP_EDGE_FALL = 2'h2,
		ACMP_EDGE_RISE = 2'h3
	} acmp_edge_type;

	// Hysteresis encodings.
	typedef enum logic [1:0]
	{
		ACMP_HYST_OFF = 2'h0,
		ACMP_HYST_10 = 2'h1,
		ACMP_HYST_25 = 2'h2,
		ACMP_HYST_50 = 2'h3
	} acmp_hyst_type;

	// Negative input encodings.
	typedef enum logic [1:0]
	{
		ACMP_NEG_PIN0 = 2'h0,
		ACMP_NEG_PIN1 = 2'h1,
		ACMP_NEG_VREF = 2'h2,
		ACMP_NEG_CONV = 2'h3
	} acmp_neg_type;

	// Settings handed to the analog core.
	typedef struct packed
	{
		logic enable;
		acmp_hyst_type hysteresis;
		logic [1:0] positive_sel;
		acmp_neg_type negative_sel;
	} acmp_analog_type;

	// Register bus request from software.
	typedef struct packed
	{
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} acmp_bus_type;

	// Edge match test for the selected mode; reserved never matches.
	function automatic logic acmp_edge_hit(input logic [1:0] mode,
		input logic prev, input logic curr);
		logic rise;
		logic fall;
		rise = curr & ~prev;
		fall = prev & ~curr;
		case (mode)
			ACMP_EDGE_ANY: acmp_edge_hit = rise | fall;
			ACMP_EDGE_FALL: acmp_edge_hit = fall;
			ACMP_EDGE_RISE: acmp_edge_hit = rise;
			default: acmp_edge_hit = 1'b0;
		endcase
	endfunction : acmp_edge_hit

endpackage : acmp_pkg

// ==== sim/acmp_props_properties.sv ====
`timescale 1ns/1ns
// Port checker; shadows the writable registers from observed writes.
module acmp_props
	import acmp_pkg::*;
(
	// Clock, reset and register bus.
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire acmp_bus_type bus_i,
	input wire logic [7:0] rdata_o,
	// Sleep state and analog core.
	input wire logic standby_i,
	input wire logic power_down_i,
	input wire logic cmp_raw_i,
	input wire acmp_analog_type analog_o,
	// Pad, event and interrupt.
	input wire logic pad_o,
	input wire logic pad_oe_o,
	input wire logic event_o,
	input wire logic irq_o
);
	logic [7:0] c; // Control shadow.
	logic [7:0] m; // Input select shadow.
	logic ie; // Interrupt enable shadow.
	logic res; // Result after the optional inversion.
	logic clr; // Software is dropping the request this cycle.
	assign res = cmp_raw_i ^ m[7];
	assign clr = bus_i.wr && (bus_i.addr == ACMP_STATUS_ADDR && bus_i.wdata[0]
		|| bus_i.addr == ACMP_IRQEN_ADDR && !bus_i.wdata[0]);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Shadows move on the same edge as the real registers.
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
			{c, m, ie} <= 17'h0_0000;
		else if (bus_i.wr)
			case (bus_i.addr)
				ACMP_CTRL_ADDR: c <= bus_i.wdata & ACMP_CTRL_MASK;
				ACMP_MUX_ADDR: m <= bus_i.wdata & ACMP_MUX_MASK;
				ACMP_IRQEN_ADDR: ie <= bus_i.wdata[0];
				default: ;
			endcase
	end
	a_pad_gate: assert property (!c[6] || power_down_i |-> !pad_oe_o)
		else $error("Pad driven while off.");
	a_pad_data: assert property (pad_oe_o |-> pad_o == res)
		else $error("Pad value wrong.");
	a_event_out: assert property (event_o == (analog_o.enable & res))
		else $error("Event value wrong.");
	a_core_enable: assert property (
		analog_o.enable == (c[0] & ~power_down_i & (~standby_i | c[7])))
		else $error("Core enable wrong.");
	a_core_fields: assert property (
		{analog_o.hysteresis, analog_o.positive_sel, analog_o.negative_sel}
		== {c[2:1], m[4:3], m[1:0]})
		else $error("Core settings wrong.");
	a_irq_gate: assert property (irq_o |-> ie)
		else $error("Request while disabled.");
	a_irq_sleep: assert property (standby_i && !bus_i.wr |=> !$rose(irq_o))
		else $error("Request raised in standby.");
	a_irq_hold: assert property (irq_o && !clr |=> irq_o)
		else $error("Request dropped early.");
endmodule : acmp_props
bind acmp_comparator_control_regs acmp_props u_props (.sys_clk_i, .rst_n_i,
	.bus_i, .rdata_o, .standby_i, .power_down_i, .cmp_raw_i, .analog_o,
	.pad_o, .pad_oe_o, .event_o, .irq_o);

// ==== sim/acmp_core_model.sv ====
`timescale 1ns/1ns
// Stand-in for the analog comparator behind the block.
module acmp_core_model
	import acmp_pkg::*;
(
	// Settings from the block and the wanted comparison.
	input wire acmp_analog_type analog_i,
	input wire logic level_i,
	// Comparator output.
	output logic raw_o
);
	// An idle core gives no result, so the output sits low.
	assign raw_o = analog_i.enable & level_i;
endmodule : acmp_core_model

// ==== sim/acmp_comparator_control_regs_tb.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) miss(); end
// Drives the register port and the core model, scores read data.
module acmp_comparator_control_regs_tb
	import acmp_pkg::*;
;
	logic sys_clk_i, rst_n_i, standby_i, power_down_i, cmp_raw_i;
	logic pad_o, pad_oe_o, event_o, irq_o;
	logic level; // Comparison the model shows.
	logic pend; // A read was taken at the last edge.
	logic [1:0] md; // Edge mode under test.
	logic [7:0] rdata_o;
	logic [31:0] seed;
	logic [7:0] exp_q[$]; // Expected read data, oldest first.
	logic [2:0] adr[3] = '{ACMP_CTRL_ADDR, ACMP_MUX_ADDR, ACMP_IRQEN_ADDR};
	logic [7:0] msk[3] = '{ACMP_CTRL_MASK, ACMP_MUX_MASK, ACMP_IRQEN_MASK};
	acmp_bus_type bus_i;
	acmp_analog_type analog_o;
	int fail_count = 0;
	int tests_run = 0;
	acmp_comparator_control_regs u_dut (.sys_clk_i, .rst_n_i, .bus_i,
		.rdata_o, .standby_i, .power_down_i, .cmp_raw_i, .analog_o,
		.pad_o, .pad_oe_o, .event_o, .irq_o);
	acmp_core_model u_core (.analog_i(analog_o), .level_i(level),
		.raw_o(cmp_raw_i));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic miss();
		fail_count++;
		$display("[FAIL] %0t mismatch", $time);
	endtask : miss
	task automatic conclude();
		if (fail_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude
	// A gap cycle follows every strobe so none is driven twice at one edge.
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		bus_i <= '{a, d, 1'b1, 1'b0};
		@(posedge sys_clk_i);
		bus_i <= '0;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge sys_clk_i);
		bus_i <= '{a, 8'h00, 1'b0, 1'b1};
		exp_q.push_back(e);
		@(posedge sys_clk_i);
		bus_i <= '0;
	endtask : rd
	// The result needs about four cycles to reach the flag.
	task automatic put(input logic v);
		@(posedge sys_clk_i);
		level <= v;
		repeat (6) @(posedge sys_clk_i);
	endtask : put
	initial
	begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	// Read data stands one cycle only, so it is taken mid-cycle.
	always @(posedge sys_clk_i) pend <= bus_i.rd;
	always @(negedge sys_clk_i)
	begin
		if (pend && exp_q.size() > 0)
			`CHK(rdata_o, exp_q.pop_front())
	end
	initial
	begin
		repeat (3000) @(posedge sys_clk_i);
		fail_count++;
		conclude();
	end
	initial
	begin
		{rst_n_i, standby_i, power_down_i, level} = 4'h0;
		bus_i = '0;
		seed = 32'haf3f_0dd4;
		repeat (12) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
		// Random settings read back through the reserved masks.
		for (int i = 0; i < 9; i++)
		begin
			seed = lfsr(seed);
			wr(adr[i % 3], seed[7:0]);
			rd(adr[i % 3], seed[7:0] & msk[i % 3]);
		end
		wr(ACMP_MUX_ADDR, 8'h00);
		wr(ACMP_IRQEN_ADDR, 8'h01);
		// Each edge mode meets a rise and a fall; the reserved one never fires.
		for (int k = 0; k < 4; k++)
		begin
			md = k[1:0];
			wr(ACMP_CTRL_ADDR, {2'b01, md, 4'h1});
			put(1'b0);
			wr(ACMP_STATUS_ADDR, 8'h01);
			put(1'b1);
			rd(ACMP_STATUS_ADDR, {4'h1, 3'h0, md == 0 || md == 3});
			wr(ACMP_STATUS_ADDR, 8'h00);
			@(negedge sys_clk_i);
			`CHK(irq_o, md == 0 || md == 3)
			wr(ACMP_STATUS_ADDR, 8'h01);
			put(1'b0);
			rd(ACMP_STATUS_ADDR, {4'h0, 3'h0, md == 0 || md == 2});
		end
		wr(ACMP_MUX_ADDR, 8'h80);
		put(1'b0);
		rd(ACMP_STATUS_ADDR, 8'h11);
		wr(ACMP_MUX_ADDR, 8'h00);
		wr(ACMP_CTRL_ADDR, 8'hC1);
		// Let the fall from dropping the inversion land before clearing.
		put(1'b0);
		wr(ACMP_STATUS_ADDR, 8'h01);
		// Standby with the run bit: the event follows, the flag stays clear.
		standby_i <= 1'b1;
		put(1'b1);
		`CHK(event_o, 1'b1)
		standby_i <= 1'b0;
		put(1'b1);
		rd(ACMP_STATUS_ADDR, 8'h10);
		power_down_i <= 1'b1;
		@(negedge sys_clk_i);
		`CHK(pad_oe_o, 1'b0)
		conclude();
	end
endmodule : acmp_comparator_control_regs_tb
